// >>> hdl/hs_ls_coupling_map.sv
// Coupling map registers and per-channel coupling and bootstrap logic
//
// What this block does
// RQ1 - Mapped low-side on drives coupling high
// RQ2 - Register 0x1A6 holds channels one and two
// RQ3 - Register 0x1A7 holds channels three and four
// RQ4 - Register 0x1A8 holds channel five, rest zero
// RQ5 - Software maps low-sides sharing the load
// RQ6 - Override forces channels one, two low
// RQ7 - Override forces channels three to five high
// RQ8 - High coupling ends bootstrap initialization
// RQ9 - Software overrides every unused high-side
// RQ10 - Fields read back, writes ignored when locked
`timescale 1ns/1ps
`include "hs_ls_coupling_map.svh"
module hs_ls_coupling_map
    import hs_ls_coupling_pkg::*;
#(
    parameter int NUM_HS = 5,
    parameter int NUM_LS = 7
) (
    // Clock and reset
    input wire logic CLK_SYS,
    input wire logic NRST,
    // Register access port
    input wire logic [8:0] REG_ADDR,
    input wire logic [15:0] REG_WDATA,
    input wire logic REG_WE,
    input wire logic REG_RE,
    output logic [15:0] REG_RDATA,
    // Device register lock
    input wire logic REG_LOCK,
    // Low-side pre-driver on-states
    input wire logic [NUM_LS-1:0] LS_ON,
    // Per high-side coupling signal
    output logic [NUM_HS-1:0] HIGH_SIDE_COUPLING_SIGNAL,
    // Per high-side bootstrap initialization still running
    output logic [NUM_HS-1:0] BOOT_INIT_ACTIVE
);

    ////////////////////////////////////////////////////////////////////////
    // Storage
    ////////////////////////////////////////////////////////////////////////

    // Map and override per channel
    cpl_field_t field_r [NUM_HS];
    // Registered coupling level
    logic [NUM_HS-1:0] coupling_r;
    // Combinational coupling level
    logic [NUM_HS-1:0] coupling_nxt;
    // Read data register and its next value
    reg_data_t rdata_r;
    reg_data_t rdata_nxt;

    // Writes pass only while unlocked
    wire wr_ok = REG_WE && !REG_LOCK;
    // Address hits
    wire hit_hs12 = (REG_ADDR == `CPL_ADDR_HS12);
    wire hit_hs34 = (REG_ADDR == `CPL_ADDR_HS34);
    wire hit_hs5 = (REG_ADDR == `CPL_ADDR_HS5);

    ////////////////////////////////////////////////////////////////////////
    // Per-channel field, combiner and bootstrap phase
    ////////////////////////////////////////////////////////////////////////

    for (genvar ch = 0; ch < NUM_HS; ch++) begin : g_ch
        // Register holding this channel: two channels per word, channel five alone in the last
        localparam reg_addr_t ADDR = reg_addr_t'(`CPL_ADDR_HS12 + ch / 2);
        // Channels two and four sit in the high byte
        localparam bit HI = (ch % 2) == 1;
        // Pair one and two force low, the rest force high
        localparam logic FORCE =
            (ch < `CPL_LOW_FORCE_CHANNELS) ? `CPL_FORCE_HS12 : `CPL_FORCE_HS345;

        // Write strobe and byte for this channel
        wire field_we = wr_ok && (REG_ADDR == ADDR);
        wire [7:0] field_wdata = HI ? REG_WDATA[`CPL_HI_MSB:`CPL_HI_LSB]
                                    : REG_WDATA[`CPL_FIELD_W-1:0];

        // Bootstrap phase of this high-side channel
        boot_state_t boot_r;

        // RQ2 RQ3 RQ4 field storage
        // RQ10 locked writes dropped
        always_ff @(posedge CLK_SYS or negedge NRST) begin
            if (!NRST) begin
                field_r[ch] <= `CPL_FIELD_RESET;
            end else if (field_we) begin
                field_r[ch] <= field_wdata;
            end
        end

        // RQ1 RQ6 RQ7 combining per channel
        coupling_combiner #(
            .NUM_LS(NUM_LS),
            .FORCE_LEVEL(FORCE)
        ) u_comb (
            .map(field_r[ch][`CPL_MAP_MSB:0]),
            .override(field_r[ch][`CPL_OVR_BIT]),
            .ls_on(LS_ON),
            .coupling(coupling_nxt[ch])
        );

        // RQ8 coupling ends initialization
        // Once left, the phase is not re-entered until reset
        always_ff @(posedge CLK_SYS or negedge NRST) begin
            if (!NRST) begin
                boot_r <= BOOT_INIT;
            end else begin
                case (boot_r)
                    // Waiting for a coupling pulse
                    BOOT_INIT: begin
                        if (coupling_r[ch]) begin
                            boot_r <= BOOT_DONE;
                        end
                    end
                    // Stays done
                    BOOT_DONE: begin
                        boot_r <= BOOT_DONE;
                    end
                    // Safe recovery
                    default: begin
                        boot_r <= BOOT_INIT;
                    end
                endcase
            end
        end

        // Phase status out
        assign BOOT_INIT_ACTIVE[ch] = (boot_r == BOOT_INIT);
    end

    ////////////////////////////////////////////////////////////////////////
    // Coupling output register
    ////////////////////////////////////////////////////////////////////////

    // One flop stage so the output is glitch-free
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            coupling_r <= '0;
        end else begin
            coupling_r <= coupling_nxt;
        end
    end

    assign HIGH_SIDE_COUPLING_SIGNAL = coupling_r;

    ////////////////////////////////////////////////////////////////////////
    // Read path
    ////////////////////////////////////////////////////////////////////////

    // RQ10 read back; RQ4 reserved byte zero
    // Unmapped addresses read zero
    assign rdata_nxt = hit_hs12 ? {field_r[1], field_r[0]} :
                       hit_hs34 ? {field_r[3], field_r[2]} :
                       hit_hs5 ? {`CPL_RESERVED_READ, field_r[4]} :
                       `CPL_RDATA_RESET;

    // Read data held until the next read
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            rdata_r <= `CPL_RDATA_RESET;
        end else if (REG_RE) begin
            rdata_r <= rdata_nxt;
        end
    end

    assign REG_RDATA = rdata_r;

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    ////////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!NRST);

    // Unlocked write to a given word
    sequence s_wr12;
        REG_WE && !REG_LOCK && hit_hs12;
    endsequence
    sequence s_wr34;
        REG_WE && !REG_LOCK && hit_hs34;
    endsequence

    property p_wr_hs12;
        s_wr12 |=> ({field_r[1], field_r[0]} == $past(REG_WDATA));
    endproperty
    a_wr_hs12: assert property (p_wr_hs12) // RQ2
        else $error("Word one-two not stored");

    property p_wr_hs34;
        s_wr34 |=> ({field_r[3], field_r[2]} == $past(REG_WDATA));
    endproperty
    a_wr_hs34: assert property (p_wr_hs34) // RQ3
        else $error("Word three-four not stored");

    // Field taken from before the read edge: a write in the same cycle
    // must not show up in the returned word
    property p_rd_hs5;
        REG_RE && hit_hs5 |=> (REG_RDATA[`CPL_HI_MSB:`CPL_HI_LSB] ==
            `CPL_RESERVED_READ) && (REG_RDATA[`CPL_FIELD_W-1:0] ==
            $past(field_r[4]));
    endproperty
    a_rd_hs5: assert property (p_rd_hs5) // RQ4
        else $error("Word five read back wrong");

    property p_locked;
        REG_WE && REG_LOCK |=> ({field_r[1], field_r[0]} ==
            $past({field_r[1], field_r[0]}));
    endproperty
    a_locked: assert property (p_locked) // RQ10
        else $error("Locked write changed a field");

    property p_or_hs3;
        !field_r[2][`CPL_OVR_BIT] && |(field_r[2][`CPL_MAP_MSB:0] & LS_ON)
            |=> HIGH_SIDE_COUPLING_SIGNAL[2];
    endproperty
    a_or_hs3: assert property (p_or_hs3) // RQ1
        else $error("Mapped low-side on did not couple");

    property p_idle_hs1;
        !field_r[0][`CPL_OVR_BIT] && !(|(field_r[0][`CPL_MAP_MSB:0] & LS_ON))
            |=> !HIGH_SIDE_COUPLING_SIGNAL[0];
    endproperty
    a_idle_hs1: assert property (p_idle_hs1) // RQ1
        else $error("Coupling high with no mapped activity");

    property p_ovr_hs2;
        field_r[1][`CPL_OVR_BIT] |=>
            (HIGH_SIDE_COUPLING_SIGNAL[1] == `CPL_FORCE_HS12);
    endproperty
    a_ovr_hs2: assert property (p_ovr_hs2) // RQ6
        else $error("Override level wrong on channel two");

    property p_ovr_hs5;
        field_r[4][`CPL_OVR_BIT] |=> HIGH_SIDE_COUPLING_SIGNAL[4];
    endproperty
    a_ovr_hs5: assert property (p_ovr_hs5) // RQ7
        else $error("Override did not force channel five high");

    property p_boot_end;
        HIGH_SIDE_COUPLING_SIGNAL[3] |=> !BOOT_INIT_ACTIVE[3] [*2];
    endproperty
    a_boot_end: assert property (p_boot_end) // RQ8
        else $error("Bootstrap phase not ended by coupling");

endmodule // hs_ls_coupling_map

// >>> hdl/hs_ls_coupling_map.svh
// Register map and field layout for the high-side / low-side coupling bank
`ifndef HS_LS_COUPLING_MAP_SVH
`define HS_LS_COUPLING_MAP_SVH

// Register addresses
`define CPL_ADDR_HS12 9'h1A6
`define CPL_ADDR_HS34 9'h1A7
`define CPL_ADDR_HS5 9'h1A8

// Per-channel field: seven map bits, then the override bit
`define CPL_FIELD_W 8
`define CPL_OVR_BIT 7
`define CPL_MAP_MSB 6
`define CPL_HI_LSB 8
`define CPL_HI_MSB 15

// Reset values
`define CPL_FIELD_RESET 8'h7F
`define CPL_RESERVED_READ 8'h00
`define CPL_RDATA_RESET 16'h0000

// Forced coupling level while overridden
`define CPL_FORCE_HS12 1'b0
`define CPL_FORCE_HS345 1'b1

// Channels below this index use the low forced level
`define CPL_LOW_FORCE_CHANNELS 2

`endif

// >>> hdl/hs_ls_coupling_pkg.sv
// Types shared by the coupling bank and its combiner
package hs_ls_coupling_pkg;
    // Register address and data
    typedef logic [8:0] reg_addr_t;
    typedef logic [15:0] reg_data_t;
    // One channel field: map plus override
    typedef logic [7:0] cpl_field_t;
    // Bootstrap phase of one high-side channel
    typedef enum logic {BOOT_INIT, BOOT_DONE} boot_state_t;
endpackage

// >>> hdl/coupling_combiner.sv
// Combines low-side on-states into one high-side coupling level
`timescale 1ns/1ps
module coupling_combiner
    import hs_ls_coupling_pkg::*;
#(
    parameter int NUM_LS = 7,
    parameter logic FORCE_LEVEL = 1'b1
) (
    // Configuration
    input wire logic [NUM_LS-1:0] map,
    input wire logic override,
    // Low-side on-states
    input wire logic [NUM_LS-1:0] ls_on,
    // Result
    output logic coupling
);
    // Any mapped low-side driver that is on
    wire any_mapped_on = |(map & ls_on);

    // Override wins over the low-side activity
    assign coupling = override ? FORCE_LEVEL : any_mapped_on;
endmodule // coupling_combiner

// >>> verif/tb_hs_ls_coupling_map.sv
// Self-checking bench for the coupling map bank and its coupling outputs
`timescale 1ns/1ps
`include "hs_ls_coupling_map.svh"
module tb_hs_ls_coupling_map
    import hs_ls_coupling_pkg::*;
;
    ////////////////////////////////////////////////////////////////////////
    // Stimulus and observed signals
    logic CLK_SYS = 1'b0; // System clock, 25 ns
    logic NRST = 1'b0; // Held low at start
    reg_addr_t REG_ADDR = 9'h000;
    reg_data_t REG_WDATA = 16'h0000;
    logic REG_WE = 1'b0;
    logic REG_RE = 1'b0;
    logic REG_LOCK = 1'b0;
    logic [6:0] LS_ON = 7'h00; // Low-sides all off
    reg_data_t REG_RDATA;
    logic [4:0] HIGH_SIDE_COUPLING_SIGNAL;
    logic [4:0] BOOT_INIT_ACTIVE;
    int fails = 0; // Mismatch count
    int checked = 0; // Comparison count
    int cycles = 0; // Hang guard
    cpl_field_t fld [5]; // Mirror of the five channel fields
    logic [4:0] boot_exp; // Channels still initialising

    ////////////////////////////////////////////////////////////////////////
    // Clock and device under test
    always #12.5 CLK_SYS = ~CLK_SYS;

    hs_ls_coupling_map i_dut (
        .CLK_SYS(CLK_SYS), .NRST(NRST), .REG_ADDR(REG_ADDR),
        .REG_WDATA(REG_WDATA), .REG_WE(REG_WE), .REG_RE(REG_RE),
        .REG_RDATA(REG_RDATA), .REG_LOCK(REG_LOCK), .LS_ON(LS_ON),
        .HIGH_SIDE_COUPLING_SIGNAL(HIGH_SIDE_COUPLING_SIGNAL),
        .BOOT_INIT_ACTIVE(BOOT_INIT_ACTIVE)
    );

    ////////////////////////////////////////////////////////////////////////
    // Verdict, comparisons and bus tasks
    task automatic report_and_stop();
        if (fails == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk16(input reg_data_t got, input reg_data_t exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk5(input logic [4:0] got, input logic [4:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Inputs move 1 ns after the rising edge
    task automatic step();
        @(posedge CLK_SYS);
        #1;
    endtask

    // Strobe dropped, then one idle cycle so no double drive
    task automatic wr(input reg_addr_t a, input reg_data_t d);
        REG_ADDR = a;
        REG_WDATA = d;
        REG_WE = 1'b1;
        step();
        REG_WE = 1'b0;
        step();
    endtask

    // Data registered at the taking edge; sampled a cycle later
    task automatic rd_chk(input reg_addr_t a, input reg_data_t exp);
        REG_ADDR = a;
        REG_RE = 1'b1;
        step();
        REG_RE = 1'b0;
        step();
        chk16(REG_RDATA, exp);
    endtask

    // Load all three registers and the mirror
    task automatic cfg(input reg_data_t d12, d34, d5);
        wr(`CPL_ADDR_HS12, d12);
        wr(`CPL_ADDR_HS34, d34);
        wr(`CPL_ADDR_HS5, d5);
        fld = '{d12[7:0], d12[15:8], d34[7:0], d34[15:8], d5[7:0]};
        step();
    endtask

    // Expected coupling from mirror and low-side states
    function automatic logic [4:0] exp_cpl(input logic [6:0] ls);
        logic [4:0] e;
        for (int ch = 0; ch < 5; ch++) begin
            if (fld[ch][`CPL_OVR_BIT]) begin
                e[ch] = (ch >= `CPL_LOW_FORCE_CHANNELS);
            end else begin
                e[ch] = |(fld[ch][6:0] & ls);
            end
        end
        return e;
    endfunction

    // Apply low-sides, check coupling and bootstrap phase
    task automatic ls_chk(input logic [6:0] ls);
        LS_ON = ls;
        step();
        step();
        chk5(HIGH_SIDE_COUPLING_SIGNAL, exp_cpl(ls));
        boot_exp = boot_exp & ~exp_cpl(ls);
        chk5(BOOT_INIT_ACTIVE, boot_exp);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Hang guard
    always @(posedge CLK_SYS) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            report_and_stop();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        boot_exp = 5'h1F;
        repeat (5) @(posedge CLK_SYS);
        #1;
        NRST = 1'b1;
        step();
        rd_chk(`CPL_ADDR_HS12, 16'h7F7F);
        rd_chk(`CPL_ADDR_HS34, 16'h7F7F);
        rd_chk(`CPL_ADDR_HS5, 16'h007F);
        chk5(BOOT_INIT_ACTIVE, 5'h1F);
        REG_LOCK = 1'b1;
        wr(`CPL_ADDR_HS12, 16'h0000);
        REG_LOCK = 1'b0;
        rd_chk(`CPL_ADDR_HS12, 16'h7F7F);
        wr(9'h1A9, 16'hFFFF);
        rd_chk(9'h1A9, 16'h0000);
        wr(`CPL_ADDR_HS5, 16'hFFFF);
        rd_chk(`CPL_ADDR_HS5, 16'h00FF);
        // Override on channel five forces it high and ends its init
        boot_exp = 5'h0F;
        chk5(HIGH_SIDE_COUPLING_SIGNAL, 5'h10);
        chk5(BOOT_INIT_ACTIVE, boot_exp);
        // one low-side per load, overrides cleared
        cfg(16'h0201, 16'h0804, 16'h0010);
        rd_chk(`CPL_ADDR_HS34, 16'h0804);
        for (int i = 0; i < 7; i++) begin
            ls_chk(7'(1 << i));
        end
        // every channel overridden, hs1 map still full
        cfg(16'hFFFF, 16'hFFFF, 16'h00FF);
        ls_chk(7'h7F);
        ls_chk(7'h00);
        // Mid-run reset: fields, read data and init phase start over
        NRST = 1'b0;
        step();
        NRST = 1'b1;
        chk16(REG_RDATA, 16'h0000);
        chk5(HIGH_SIDE_COUPLING_SIGNAL, 5'h00);
        chk5(BOOT_INIT_ACTIVE, 5'h1F);
        rd_chk(`CPL_ADDR_HS12, 16'h7F7F);
        // Reset maps: any low-side couples every channel
        fld = '{default: 8'h7F};
        boot_exp = 5'h1F;
        ls_chk(7'h40);
        report_and_stop();
    end
endmodule // tb_hs_ls_coupling_map
